// ### card_adapter_pkg.sv
// Shared constants for the card reader-punch adapter, plus its column FIFO.
// Assumes a host micro-bus on the same clock as the adapter and a
// card reader-punch whose pins are asynchronous to that clock.
//
// Overview of operation
// - Command byte loads from bus bits 0-7, readable
// - Low nibble 0000, 1000, 1100 is invalid
// - Invalid command rejects only at start-operation
// - Punch register loads bus bits 0-11
// - Raw bit selects punch lines, readable back
// - Inbound register captures column on busy rise
// - Host reads inbound converted or raw
// - Multiple low-seven bits set flags data check, except in raw mode
// - Selected read of a used row drives bus, otherwise undriven
// - Status and sense words report listed conditions
// - Write rows decode into seven actions
// - Unused rows set command reject
// - Start while ready sets running; halt clears
// - Idle adapter: only attention, no transfers
// - Valid ready start sets card advance
// - Card advance clears on idle or pass end
// - Busy strobe sets host request and occupied
// - Inbound read or clear-status clears occupied
// - Busy while occupied sets loss, no load
// - Not-ready start rejects; reject blocks feed
// - Service request on attention, or events

package card_adapter_pkg;

	// ==========================================================
	// Host access
	localparam logic [3:0] ADAPTER_COLUMN     = 4'h3;
	localparam logic [2:0] RD_ROW_INBOUND     = 3'h0;
	localparam logic [2:0] RD_ROW_PUNCH       = 3'h1;
	localparam logic [2:0] RD_ROW_COMMAND     = 3'h2;
	localparam logic [2:0] RD_ROW_STATUS      = 3'h3;
	localparam logic [2:0] RD_ROW_SENSE       = 3'h4;
	localparam logic [2:0] WR_ROW_LOAD_IN     = 3'h0;
	localparam logic [2:0] WR_ROW_LOAD_CMD    = 3'h1;
	localparam logic [2:0] WR_ROW_LOAD_PUNCH  = 3'h2;
	localparam logic [2:0] WR_ROW_START       = 3'h3;
	localparam logic [2:0] WR_ROW_HALT        = 3'h4;
	localparam logic [2:0] WR_ROW_CLEAR       = 3'h5;
	localparam logic [2:0] WR_ROW_RESET_DEV   = 3'h6;

	// ==========================================================
	// Command byte fields and reset values
	localparam int         CMD_RAW_BIT        = 4;
	localparam logic [3:0] OP_INVALID_A       = 4'h0;
	localparam logic [3:0] OP_INVALID_B       = 4'h8;
	localparam logic [3:0] OP_INVALID_C       = 4'hC;
	localparam logic [7:0] COMMAND_RESET      = 8'h00;
	localparam logic [11:0] COLUMN_RESET      = 12'h000;

	// ==========================================================
	// Status word bit positions
	localparam int ST_ATTENTION   = 4;
	localparam int ST_BUSY        = 3;
	localparam int ST_DEVICE_END  = 2;
	localparam int ST_UNIT_CHECK  = 1;
	localparam int ST_REQUEST_IN  = 0;

	// Sense word bit positions
	localparam int SN_REJECT      = 6;
	localparam int SN_INTERVENE   = 5;
	localparam int SN_DATA_CHECK  = 4;
	localparam int SN_LOSS        = 3;
	localparam int SN_NOT_READY   = 2;
	localparam int SN_DEV_STATUS  = 1;
	localparam int SN_HOST_REQ    = 0;

	// ==========================================================
	// Column buffering
	localparam int COLUMN_WIDTH   = 12;
	localparam int FIFO_DEPTH     = 16;

endpackage

// ### column_fifo.sv
// Column FIFO: flip-flop storage with valid/ready on both sides.
// Assumes one clock and asynchronous active-low reset.
`timescale 1ns/10ps

module column_fifo
#(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
)
(
	input  wire logic             i_clock,
	input  wire logic             i_nrst,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	assign o_in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign o_out_valid = (count_reg != '0);
	assign o_out_data  = mem_reg[rd_ptr_reg];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_ff @(posedge i_clock)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= i_in_data;
	end

	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0
					: wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0
					: rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end

endmodule

// ### card_adapter.sv
// Card reader-punch adapter: host register decode, flags, peripheral link.
// Assumes host strobes on i_clock; peripheral pins asynchronous.
`timescale 1ns/10ps

module card_adapter
#(
	parameter logic [3:0] COLUMN = card_adapter_pkg::ADAPTER_COLUMN
)
(
	input  wire logic        i_clock,
	input  wire logic        i_nrst,
	input  wire logic [3:0]  i_column_addr,
	input  wire logic [2:0]  i_row_addr,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [15:0] i_bus_data,
	output logic      [15:0] o_bus_data,
	output logic             o_bus_oe,
	output logic             o_service_request,
	input  wire logic [11:0] i_card_data,
	input  wire logic        i_busy,
	input  wire logic        i_card_pass_complete,
	input  wire logic        i_ready,
	input  wire logic        i_status_line,
	input  wire logic        i_error_strobe,
	output logic             o_feed_command,
	output logic      [11:0] o_punch_data
);
	import card_adapter_pkg::*;

	// ==========================================================
	// Pin synchronisers: 3 stages, level accepted when 2 and 3 agree
	localparam int NPIN = 5;
	localparam int P_BUSY = 4;
	localparam int P_PASS = 3;
	localparam int P_READY = 2;
	localparam int P_STAT = 1;
	localparam int P_ERR = 0;

	logic [NPIN-1:0] pins;
	logic [NPIN-1:0] s1_reg;
	logic [NPIN-1:0] s2_reg;
	logic [NPIN-1:0] s3_reg;
	logic [NPIN-1:0] lvl_reg;
	logic [NPIN-1:0] lvl_prev_reg;
	logic [11:0]     card_s1_reg;
	logic [11:0]     card_s2_reg;
	logic [11:0]     card_s3_reg;
	logic [NPIN-1:0] rise;
	logic [NPIN-1:0] fall;

	assign pins = {i_busy, i_card_pass_complete, i_ready,
		i_status_line, i_error_strobe};

	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			s1_reg       <= '0;
			s2_reg       <= '0;
			s3_reg       <= '0;
			lvl_reg      <= '0;
			lvl_prev_reg <= '0;
			card_s1_reg  <= COLUMN_RESET;
			card_s2_reg  <= COLUMN_RESET;
			card_s3_reg  <= COLUMN_RESET;
		end
		else
		begin
			s1_reg       <= pins;
			s2_reg       <= s1_reg;
			s3_reg       <= s2_reg;
			lvl_prev_reg <= lvl_reg;
			card_s1_reg  <= i_card_data;
			card_s2_reg  <= card_s1_reg;
			card_s3_reg  <= card_s2_reg;
			for (int i = 0; i < NPIN; i++)
				if (s2_reg[i] == s3_reg[i])
					lvl_reg[i] <= s3_reg[i];
		end
	end

	assign rise = lvl_reg & ~lvl_prev_reg;
	assign fall = ~lvl_reg & lvl_prev_reg;

	// ==========================================================
	// Host decode
	logic sel;
	logic rd;
	logic wr;
	logic ld_in;
	logic ld_cmd;
	logic ld_punch;
	logic start_op;
	logic halt_op;
	logic clear_st;
	logic reset_dev;
	logic rd_inbound;
	logic illegal;

	assign sel        = (i_column_addr == COLUMN);
	assign rd         = sel && i_read;
	assign wr         = sel && i_write && !i_read;
	assign ld_in      = wr && (i_row_addr == WR_ROW_LOAD_IN);
	assign ld_cmd     = wr && (i_row_addr == WR_ROW_LOAD_CMD);
	assign ld_punch   = wr && (i_row_addr == WR_ROW_LOAD_PUNCH);
	assign start_op   = wr && (i_row_addr == WR_ROW_START);
	assign halt_op    = wr && (i_row_addr == WR_ROW_HALT);
	assign clear_st   = wr && (i_row_addr == WR_ROW_CLEAR);
	assign reset_dev  = wr && (i_row_addr == WR_ROW_RESET_DEV);
	assign rd_inbound = rd && (i_row_addr == RD_ROW_INBOUND);
	assign illegal    = (wr && (i_row_addr > WR_ROW_RESET_DEV))
		|| (rd && (i_row_addr > RD_ROW_SENSE));

	// ==========================================================
	// Registers
	logic [7:0]  command_reg;
	logic [11:0] punch_reg;
	logic [11:0] inbound_reg;
	logic [11:0] punch_out_reg;
	logic        raw_mode;
	logic        invalid_cmd;
	logic        ready_latch;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [11:0] fifo_out_data;
	logic        pop;
	logic        busy_take;
	logic        active_reg;
	logic        occupied_reg;

	assign raw_mode    = command_reg[CMD_RAW_BIT];
	assign invalid_cmd = (command_reg[3:0] == OP_INVALID_A)
		|| (command_reg[3:0] == OP_INVALID_B)
		|| (command_reg[3:0] == OP_INVALID_C);
	assign ready_latch = lvl_reg[P_READY] && lvl_reg[P_STAT];

	// Byte to card rows: [11:9] zones 12/11/0, [8:0] digit rows 1..9.
	// Compact code, not a full table; raw mode bypasses it.
	function automatic logic [11:0] byte_to_card(input logic [7:0] b);
		logic [11:0] c;
		c = {b[6:4], 9'h000};
		if ((b[3:0] != 4'h0) && (b[3:0] <= 4'h9))
			c[4'h9 - b[3:0]] = 1'b1;
		return c;
	endfunction

	function automatic logic [7:0] card_to_byte(input logic [11:0] c);
		logic [3:0] d;
		d = 4'h0;
		for (int i = 8; i >= 0; i--)
			if (c[i])
				d = 4'(9 - i);
		return {1'b0, c[11:9], d};
	endfunction

	// x & (x-1) is nonzero exactly when two or more bits are set
	function automatic logic multi_set(input logic [6:0] x);
		return (x & (x - 7'h01)) != 7'h00;
	endfunction

	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
			command_reg <= COMMAND_RESET;
		else if (ld_cmd)
			command_reg <= i_bus_data[7:0];
	end

	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			punch_reg     <= COLUMN_RESET;
			punch_out_reg <= COLUMN_RESET;
		end
		else
		begin
			if (ld_punch)
				punch_reg <= i_bus_data[11:0];
			punch_out_reg <= raw_mode ? punch_reg
				: byte_to_card(punch_reg[7:0]);
		end
	end

	// Captured columns wait in the FIFO; the inbound register takes
	// the next one only once the host has emptied it.
	assign busy_take = rise[P_BUSY] && !occupied_reg && active_reg
		&& fifo_in_ready;
	assign pop = fifo_out_valid && !occupied_reg && !ld_in;

	column_fifo
	#(
		.WIDTH (COLUMN_WIDTH),
		.DEPTH (FIFO_DEPTH)
	)
	u_fifo
	(
		.i_clock     (i_clock),
		.i_nrst      (i_nrst),
		.i_in_valid  (busy_take),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (card_s3_reg),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (!occupied_reg && !ld_in),
		.o_out_data  (fifo_out_data)
	);

	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
			inbound_reg <= COLUMN_RESET;
		else if (ld_in)
			inbound_reg <= i_bus_data[11:0];
		else if (pop)
			inbound_reg <= fifo_out_data;
	end

	// ==========================================================
	// Operation flags
	logic feed_reg;
	logic card_busy_reg;
	logic host_req_reg;
	logic loss_reg;
	logic reject_reg;
	logic attention_reg;
	logic dev_end_reg;
	logic data_check_reg;
	logic ready_prev_reg;
	logic ready_rise;

	assign ready_rise = ready_latch && !ready_prev_reg;

	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			active_reg    <= 1'b0;
			feed_reg      <= 1'b0;
			card_busy_reg <= 1'b0;
		end
		else
		begin
			if (halt_op || reset_dev)
				active_reg <= 1'b0;
			else if (start_op && ready_latch)
				active_reg <= 1'b1;
			if (start_op && ready_latch && !invalid_cmd && !reject_reg)
				feed_reg <= 1'b1;
			else if (!active_reg || fall[P_PASS])
				feed_reg <= 1'b0;
			if (start_op && ready_latch && !invalid_cmd && !reject_reg)
				card_busy_reg <= 1'b1;
			else if (!active_reg || rise[P_PASS])
				card_busy_reg <= 1'b0;
		end
	end

	// Sticky flags: a set in the same cycle as a clear wins
	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			occupied_reg   <= 1'b0;
			host_req_reg   <= 1'b0;
			loss_reg       <= 1'b0;
			reject_reg     <= 1'b0;
			attention_reg  <= 1'b0;
			dev_end_reg    <= 1'b0;
			data_check_reg <= 1'b0;
			ready_prev_reg <= 1'b0;
		end
		else
		begin
			ready_prev_reg <= ready_latch;
			if (clear_st || reset_dev)
			begin
				loss_reg       <= 1'b0;
				reject_reg     <= 1'b0;
				attention_reg  <= 1'b0;
				dev_end_reg    <= 1'b0;
				data_check_reg <= 1'b0;
			end
			if (rd_inbound || clear_st || reset_dev)
				occupied_reg <= 1'b0;
			if (rd_inbound || ld_punch || clear_st || reset_dev)
				host_req_reg <= 1'b0;
			if (pop)
				occupied_reg <= 1'b1;
			if ((busy_take || (fall[P_PASS] && active_reg))
				&& !reject_reg)
				host_req_reg <= 1'b1;
			if (rise[P_BUSY] && occupied_reg && active_reg)
				loss_reg <= 1'b1;
			if (illegal || (start_op && (invalid_cmd || !ready_latch)))
				reject_reg <= 1'b1;
			if (ready_rise)
				attention_reg <= 1'b1;
			if (ready_rise || rise[P_PASS])
				dev_end_reg <= 1'b1;
			if (rise[P_ERR] || (pop && !raw_mode
				&& multi_set(fifo_out_data[6:0])))
				data_check_reg <= 1'b1;
		end
	end

	// ==========================================================
	// Host read path and service request
	logic [15:0] read_mux;
	logic [15:0] status_word;
	logic [15:0] sense_word;
	logic        unit_check;
	logic        service_next;
	logic [15:0] bus_data_reg;
	logic        bus_oe_reg;
	logic        service_reg;

	assign unit_check = reject_reg || data_check_reg || loss_reg
		|| !ready_latch;
	assign service_next = attention_reg || (active_reg
		&& (host_req_reg || dev_end_reg || loss_reg || reject_reg
		|| data_check_reg || !ready_latch));

	always_comb
	begin
		status_word                = 16'h0000;
		status_word[ST_ATTENTION]  = attention_reg;
		status_word[ST_BUSY]       = card_busy_reg;
		status_word[ST_DEVICE_END] = dev_end_reg;
		status_word[ST_UNIT_CHECK] = unit_check;
		status_word[ST_REQUEST_IN] = service_reg;
		sense_word                 = 16'h0000;
		sense_word[SN_REJECT]      = reject_reg;
		sense_word[SN_INTERVENE]   = !ready_latch;
		sense_word[SN_DATA_CHECK]  = data_check_reg;
		sense_word[SN_LOSS]        = loss_reg;
		sense_word[SN_NOT_READY]   = !lvl_reg[P_READY];
		sense_word[SN_DEV_STATUS]  = lvl_reg[P_STAT];
		sense_word[SN_HOST_REQ]    = host_req_reg;
		case (i_row_addr)
			RD_ROW_INBOUND:
				read_mux = raw_mode ? {4'h0, inbound_reg}
					: {8'h00, card_to_byte(inbound_reg)};
			RD_ROW_PUNCH:   read_mux = {4'h0, punch_out_reg};
			RD_ROW_COMMAND: read_mux = {8'h00, command_reg};
			RD_ROW_STATUS:  read_mux = status_word;
			RD_ROW_SENSE:   read_mux = sense_word;
			default:        read_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			bus_data_reg <= 16'h0000;
			bus_oe_reg   <= 1'b0;
			service_reg  <= 1'b0;
		end
		else
		begin
			bus_oe_reg   <= rd && !illegal;
			bus_data_reg <= rd ? read_mux : 16'h0000;
			service_reg  <= service_next;
		end
	end

	assign o_bus_data        = bus_data_reg;
	assign o_bus_oe          = bus_oe_reg;
	assign o_service_request = service_reg;
	assign o_feed_command    = feed_reg;
	assign o_punch_data      = punch_out_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);

	chk_cmd_load: assert property (
		ld_cmd |=> command_reg == $past(i_bus_data[7:0]))
		else $error("command byte not loaded");
	chk_start_reject: assert property (
		start_op && invalid_cmd |=> reject_reg && !$rose(feed_reg))
		else $error("invalid start not rejected");
	chk_punch_drive: assert property (
		ld_punch && raw_mode && !$past(ld_cmd) ##1 !ld_cmd
		|=> o_punch_data == $past(i_bus_data[11:0], 2))
		else $error("raw punch data not driven");
	chk_read_oe: assert property (
		!rd |=> !o_bus_oe && o_bus_data == 16'h0000)
		else $error("bus driven without read");
	chk_illegal_row: assert property (
		illegal |=> reject_reg)
		else $error("illegal row not rejected");
	chk_idle_quiet: assert property (
		!active_reg && !attention_reg |=> !o_service_request)
		else $error("service request while idle");
	chk_feed_start: assert property (
		start_op && ready_latch && !invalid_cmd && !reject_reg
		|=> o_feed_command && active_reg)
		else $error("feed not raised on start");
	chk_feed_idle: assert property (
		!active_reg && !start_op |=> !o_feed_command)
		else $error("feed held while idle");
	chk_full_clear: assert property (
		rd_inbound && !pop |=> !occupied_reg)
		else $error("occupied not cleared by read");
	chk_loss_hold: assert property (
		rise[P_BUSY] && occupied_reg && active_reg && !ld_in
		|=> loss_reg && $stable(inbound_reg))
		else $error("overrun not flagged");
	chk_data_check: assert property (
		pop && !raw_mode && multi_set(fifo_out_data[6:0])
		|=> data_check_reg)
		else $error("bad column not flagged");

	cov_card_start: cover property (start_op ##1 o_feed_command);
	cov_column_in: cover property (busy_take ##[1:4] occupied_reg);
	cov_overrun: cover property ($rose(loss_reg));
	cov_read_in: cover property (rd_inbound && occupied_reg);

endmodule

// ### card_peripheral_model.sv
// Behavioural card reader-punch as seen from the adapter's card pins.
// Assumes the feed command is a level on the same clock as the bench.
`timescale 1ns/10ps

module card_peripheral_model
(
	input  wire logic        i_clock,
	input  wire logic        i_feed_command,
	input  wire logic [11:0] i_punch_data,
	input  wire logic        i_online,
	input  wire logic [7:0]  i_gap,
	input  wire logic [11:0] i_pattern,
	output logic      [11:0] o_card_data,
	output logic             o_busy,
	output logic             o_card_pass_complete,
	output logic             o_ready,
	output logic             o_status_line,
	output logic             o_error_strobe
);
	localparam int COLUMNS = 3;
	int k;

	// Hoppers never run dry, so status simply follows the online switch
	assign o_ready = i_online;
	assign o_status_line = i_online;

	// ==========================================================
	// Card cycle: a feed held for 12 cycles commits one whole card
	initial
	begin
		o_card_data = 12'hFFF;
		o_busy = 1'b0;
		o_card_pass_complete = 1'b0;
		o_error_strobe = 1'b0;
		forever
		begin
			@(posedge i_clock);
			if (i_feed_command === 1'b1)
				repeat (12) @(posedge i_clock);
			if (i_feed_command === 1'b1)
			begin
				for (k = 0; k < COLUMNS; k++)
				begin
					repeat (i_gap) @(posedge i_clock);
					o_card_data <= i_pattern ^ 12'(k);
					repeat (2) @(posedge i_clock);
					o_busy <= 1'b1;
					repeat (4) @(posedge i_clock);
					o_busy <= 1'b0;
					repeat (2) @(posedge i_clock);
					// Lines are not held after the column: show garbage
					o_card_data <= ~o_card_data;
				end
				o_card_pass_complete <= 1'b1;
				// Echo check: a column with all 12 rows punched is taken as a punch fault
				o_error_strobe <= (i_punch_data == 12'hFFF);
				repeat (8) @(posedge i_clock);
				o_card_pass_complete <= 1'b0;
				o_error_strobe <= 1'b0;
				// Let the feed drop before a new one is looked for
				repeat (16) @(posedge i_clock);
			end
		end
	end
endmodule

// ### tb.sv
// Self-checking bench for the card reader-punch adapter.
// Assumes the peripheral model stands on the card pins.
`timescale 1ns/10ps

`define CHECK(got, exp) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) \
		begin \
			err_count++; \
			$display("Error at %0t: got %h exp %h", $time, got, exp); \
		end \
	end

module tb;
	import card_adapter_pkg::*;

	typedef struct {
		logic [15:0] value;
		logic [15:0] mask;
	} note_t;

	logic        clock = 1'b0;
	logic        nrst = 1'b0;
	logic [3:0]  column_addr = ADAPTER_COLUMN;
	logic [2:0]  row_addr = 3'h0;
	logic        read_en = 1'b0;
	logic        write_en = 1'b0;
	logic [15:0] bus_wdata = 16'h0000;
	logic [15:0] bus_rdata;
	logic        bus_oe;
	logic        service_request;
	logic        feed;
	logic [11:0] punch_data;
	logic [11:0] card_data;
	logic        busy;
	logic        pass_done;
	logic        ready;
	logic        status_line;
	logic        error_strobe;
	logic        online = 1'b1;
	logic [7:0]  gap = 8'd200;
	logic [11:0] pattern = 12'h000;
	logic [31:0] seed = 32'd50;
	note_t       notes[$];
	note_t       note;
	int          err_count = 0;
	int          n_compared = 0;

	always #2.5 clock = ~clock;

	card_adapter DUT (.i_clock(clock), .i_nrst(nrst),
		.i_column_addr(column_addr), .i_row_addr(row_addr),
		.i_read(read_en), .i_write(write_en), .i_bus_data(bus_wdata),
		.o_bus_data(bus_rdata), .o_bus_oe(bus_oe),
		.o_service_request(service_request), .i_card_data(card_data),
		.i_busy(busy), .i_card_pass_complete(pass_done),
		.i_ready(ready), .i_status_line(status_line),
		.i_error_strobe(error_strobe), .o_feed_command(feed),
		.o_punch_data(punch_data));

	card_peripheral_model partner (.i_clock(clock),
		.i_feed_command(feed), .i_punch_data(punch_data),
		.i_online(online), .i_gap(gap), .i_pattern(pattern),
		.o_card_data(card_data), .o_busy(busy),
		.o_card_pass_complete(pass_done), .o_ready(ready),
		.o_status_line(status_line), .o_error_strobe(error_strobe));

	// ==========================================================
	// Bus tasks and scoreboard
	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic access(input logic wr, input logic [2:0] row,
		input logic [15:0] data);
		@(posedge clock);
		row_addr <= row;
		bus_wdata <= data;
		write_en <= wr;
		read_en <= ~wr;
		@(posedge clock);
		write_en <= 1'b0;
		read_en <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] row, input logic [15:0] value,
		input logic [15:0] mask);
		notes.push_back('{value & mask, mask});
		access(1'b0, row, 16'h0000);
	endtask

	// Each driven read word is matched to the oldest note
	always @(posedge clock)
		if (bus_oe === 1'b1)
		begin
			if (notes.size() == 0)
				`CHECK(bus_oe, 1'b0)
			else
			begin
				note = notes.pop_front();
				`CHECK(bus_rdata & note.mask, note.value)
			end
		end

	task automatic wait_request();
		int i;
		i = 0;
		while (service_request !== 1'b1 && i < 2000)
		begin
			@(posedge clock);
			i++;
		end
		`CHECK(service_request, 1'b1)
	endtask

	task automatic done(input string name);
		repeat (4) @(posedge clock);
		$display("Test %s finished", name);
	endtask

	task automatic end_sim();
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clock);
		err_count++;
		end_sim();
	end

	// ==========================================================
	// Scenarios
	initial
	begin
		int n;
		logic inv;
		logic [11:0] v;
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		repeat (20) @(posedge clock);
		`CHECK(service_request, 1'b1)
		rd(RD_ROW_STATUS, 16'h0010, 16'h0010);
		rd(RD_ROW_COMMAND, 16'h0000, 16'hFFFF);
		access(1'b1, WR_ROW_CLEAR, 16'h0000);
		repeat (4) @(posedge clock);
		`CHECK(service_request, 1'b0)
		done("attention");
		for (n = 0; n < 4; n++)
		begin
			v = {4'h0, 8'(xorshift())};
			access(1'b1, WR_ROW_LOAD_CMD, {4'h0, v});
			rd(RD_ROW_COMMAND, {4'h0, v}, 16'hFFFF);
		end
		column_addr <= ~ADAPTER_COLUMN;
		access(1'b1, WR_ROW_LOAD_CMD, ~{4'h0, v});
		access(1'b0, RD_ROW_COMMAND, 16'h0000);
		column_addr <= ADAPTER_COLUMN;
		rd(RD_ROW_COMMAND, {4'h0, v}, 16'hFFFF);
		done("command");
		for (n = 0; n < 16; n++)
		begin
			inv = n[3:0] inside {OP_INVALID_A, OP_INVALID_B, OP_INVALID_C};
			access(1'b1, WR_ROW_CLEAR, 16'h0000);
			access(1'b1, WR_ROW_LOAD_CMD, {12'h001, n[3:0]});
			rd(RD_ROW_SENSE, 16'h0000, 16'h0040);
			access(1'b1, WR_ROW_START, 16'h0000);
			repeat (2) @(posedge clock);
			`CHECK(feed, ~inv)
			rd(RD_ROW_SENSE, {9'h000, inv, 6'h00}, 16'h0040);
			access(1'b1, WR_ROW_HALT, 16'h0000);
			repeat (3) @(posedge clock);
			`CHECK(feed, 1'b0)
		end
		done("opcodes");
		online <= 1'b0;
		repeat (10) @(posedge clock);
		access(1'b1, WR_ROW_CLEAR, 16'h0000);
		access(1'b1, WR_ROW_START, 16'h0000);
		repeat (2) @(posedge clock);
		`CHECK(feed, 1'b0)
		rd(RD_ROW_SENSE, 16'h0060, 16'h0060);
		online <= 1'b1;
		repeat (10) @(posedge clock);
		for (n = 0; n < 4; n++)
		begin
			access(1'b1, WR_ROW_CLEAR, 16'h0000);
			access(n == 3, n < 3 ? 3'(5 + n) : 3'h7, 16'h0000);
			rd(RD_ROW_SENSE, 16'h0040, 16'h0040);
		end
		done("rejects");
		access(1'b1, WR_ROW_LOAD_CMD, 16'h0011);
		v = 12'(xorshift());
		access(1'b1, WR_ROW_LOAD_PUNCH, {4'h0, v});
		repeat (3) @(posedge clock);
		`CHECK(punch_data, v)
		rd(RD_ROW_PUNCH, {4'h0, v}, 16'hFFFF);
		access(1'b1, WR_ROW_LOAD_IN, {4'h0, ~v});
		rd(RD_ROW_INBOUND, {4'h0, ~v}, 16'hFFFF);
		access(1'b1, WR_ROW_LOAD_CMD, 16'h0001);
		access(1'b1, WR_ROW_LOAD_IN, 16'h0800);
		rd(RD_ROW_INBOUND, 16'h0040, 16'hFFFF);
		access(1'b1, WR_ROW_LOAD_PUNCH, 16'h0045);
		rd(RD_ROW_PUNCH, 16'h0810, 16'hFFFF);
		done("registers");
		pattern <= 12'(xorshift());
		access(1'b1, WR_ROW_LOAD_CMD, 16'h0011);
		access(1'b1, WR_ROW_LOAD_PUNCH, 16'h0FFF);
		access(1'b1, WR_ROW_CLEAR, 16'h0000);
		access(1'b1, WR_ROW_START, 16'h0000);
		repeat (2) @(posedge clock);
		`CHECK(feed, 1'b1)
		for (n = 0; n < 2; n++)
		begin
			wait_request();
			rd(RD_ROW_INBOUND, {4'h0, pattern ^ 12'(n)}, 16'hFFFF);
			rd(RD_ROW_SENSE, 16'h0000, 16'h0001);
		end
		access(1'b1, WR_ROW_HALT, 16'h0000);
		repeat (3) @(posedge clock);
		`CHECK(feed, 1'b0)
		repeat (800) @(posedge clock);
		rd(RD_ROW_INBOUND, {4'h0, pattern ^ 12'h001}, 16'hFFFF);
		rd(RD_ROW_SENSE, 16'h0010, 16'h0010);
		access(1'b1, WR_ROW_LOAD_PUNCH, 16'h0000);
		done("slow card");
		gap <= 8'd12;
		pattern <= 12'(xorshift()) | 12'h003;
		access(1'b1, WR_ROW_CLEAR, 16'h0000);
		access(1'b1, WR_ROW_START, 16'h0000);
		repeat (200) @(posedge clock);
		`CHECK(feed, 1'b0)
		rd(RD_ROW_STATUS, 16'h0004, 16'h0004);
		rd(RD_ROW_SENSE, 16'h0008, 16'h0018);
		rd(RD_ROW_INBOUND, {4'h0, pattern}, 16'hFFFF);
		access(1'b1, WR_ROW_CLEAR, 16'h0000);
		rd(RD_ROW_SENSE, 16'h0000, 16'h0008);
		access(1'b1, WR_ROW_HALT, 16'h0000);
		done("overrun");
		pattern <= 12'h003;
		access(1'b1, WR_ROW_LOAD_CMD, 16'h0001);
		access(1'b1, WR_ROW_CLEAR, 16'h0000);
		access(1'b1, WR_ROW_START, 16'h0000);
		repeat (200) @(posedge clock);
		rd(RD_ROW_SENSE, 16'h0010, 16'h0010);
		access(1'b1, WR_ROW_RESET_DEV, 16'h0000);
		rd(RD_ROW_SENSE, 16'h0000, 16'h0058);
		done("data check");
		end_sim();
	end
endmodule
